// ### efs_supervisor.sv
// eFuse switch supervisor: control decode, delays, gate drive and fault flag.
// Assumes analog comparators deliver flags; the short-circuit flag is raw.
`timescale 1ns/1ps
module efs_supervisor
   import efs_pkg::*;
(
   // Clock and reset
   input  wire logic     clk_sys,
   input  wire logic     rst_n,
   // Analog comparator flags
   input  wire efs_cmp_s cmpIn,
   input  wire logic     shortCircuit,
   // Drive outputs
   output logic          gateEnable,
   output logic          dischargeOn,
   output logic          ctlPullDown,
   output logic          ctlChargeOn,
   // Power-good flag, open drain: oe low drives the pin low
   output logic          pgoodOut,
   output logic          pgoodOe
);
   efs_cmp_s              cmp;
   efs_state_e            stateR, stateNxt;
   logic [TMR_W-1:0]      tmrR;
   logic [TMR_W-1:0]      midR;
   logic [TMR_W-1:0]      ocR;
   logic [TMR_W-1:0]      ssR;
   logic                  latchR;
   logic                  scLatchR;
   logic                  hotR;
   logic                  gateR;

   // Every flag in cmpIn crosses through the filtered chain before use; shortCircuit bypasses it raw.
   efs_sync #(.W($bits(efs_cmp_s))) u_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .din     (cmpIn),
      .dout    (cmp)
   );

   // =====================================================================
   // Control decode.
   // =====================================================================
   wire supplyOk  = cmp.vddOk & cmp.vinOk;
   wire ctlOn     = cmp.ctlAbove14;
   wire ctlOff    = cmp.ctlBelow12 & ~cmp.ctlAbove08;
   wire ctlMid    = cmp.ctlBelow12 & cmp.ctlAbove08;
   wire midDone   = (midR >= TMR_W'(PD_QUAL_CYC));
   wire tmrInsDone = (tmrR >= TMR_W'(INSERT_CYC));
   wire tmrPdDone = (tmrR >= TMR_W'(PD_DELAY_CYC));
   wire pdEnter   = (stateR == ST_PDWAIT) & tmrPdDone;
   wire ocTrip    = (ocR >= TMR_W'(OC_BLANK_CYC));
   wire ssTrip    = (ssR >= TMR_W'(SS_TIMEOUT_CYC));
   wire running   = (stateR == ST_RUN);
   wire startUp   = running & ~cmp.vOutGood;
   // Non-latching start-up shorts hold the flag low while present.
   wire shortHeld = (stateR != ST_RUN && stateR != ST_LOCK) &
                    (cmp.outHigh70 | cmp.gsHigh2);
   wire fetFault  = startUp & (cmp.outHigh70 | cmp.gsHigh2) |
                    (running & cmp.vOutGood & cmp.gateFault);
   wire hotNow    = hotR;
   wire latchSet  = ocTrip | (ssTrip & fetFault) | hotNow | scLatchR;
   wire anyFault  = latchR | latchSet | shortHeld | fetFault | hotNow;
   wire toggleClr = ctlOff | ~supplyOk;

   // =====================================================================
   // State machine.
   // =====================================================================
   always_comb begin
      stateNxt = stateR;
      case (stateR)
         ST_LOCK:   if (supplyOk) stateNxt = ST_INSERT;
         ST_INSERT: if (tmrInsDone) stateNxt = ST_IDLE;
         ST_IDLE: begin
            if (ctlOn && !anyFault) stateNxt = ST_RUN;
            else if (ctlMid && midDone) stateNxt = ST_PDWAIT;
         end
         ST_RUN: begin
            if (latchSet || hotNow) stateNxt = ST_IDLE;
            else if (ctlMid && midDone) stateNxt = ST_PDWAIT;
            else if (!ctlOn && (ctlOff || ctlMid)) stateNxt = ST_IDLE;
         end
         ST_PDWAIT: begin
            if (ctlOff) stateNxt = ST_IDLE;
            else if (ctlOn) stateNxt = ST_INSERT;
            else if (tmrPdDone) stateNxt = ST_PD;
         end
         ST_PD: if (!ctlMid) stateNxt = ST_IDLE;
         default: stateNxt = ST_LOCK;
      endcase
      if (!supplyOk) stateNxt = ST_LOCK;
      // A cleared non-latching fault goes back through the 1 ms timer.
      if (stateR == ST_IDLE && stateNxt == ST_RUN && tmrR != '0) stateNxt = ST_INSERT;
   end

   // =====================================================================
   // State and shared timer.
   // =====================================================================
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         stateR <= ST_LOCK;
         tmrR   <= '0;
      end else begin
         stateR <= stateNxt;
         if (stateNxt != stateR) tmrR <= '0;
         else if (stateR == ST_IDLE) tmrR <= (tmrR != '0 || anyFault) ? TMR_W'(1) : '0;
         else if (!tmrPdDone) tmrR <= tmrR + TMR_W'(1);
      end
   end

   // =====================================================================
   // Qualification and fault timers.
   // =====================================================================
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         midR <= '0;
         ocR  <= '0;
         ssR  <= '0;
      end else begin
         midR <= (ctlMid && !midDone) ? midR + TMR_W'(1) : (ctlMid ? midR : '0);
         ocR  <= (running && cmp.vOutGood && cmp.overLimit && !ocTrip) ? ocR + TMR_W'(1) :
                 ((running && cmp.vOutGood && cmp.overLimit) ? ocR : '0);
         ssR  <= (running && !ssTrip) ? ssR + TMR_W'(1) : (running ? ssR : '0);
      end
   end

   // =====================================================================
   // Fault latches; a new set wins over the toggle clear.
   // =====================================================================
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         latchR <= 1'b0;
         hotR   <= 1'b0;
      end else begin
         if (latchSet) latchR <= 1'b1;
         else if (toggleClr) latchR <= 1'b0;
         if (cmp.hotRise) hotR <= 1'b1;
         else if (cmp.hotClear) hotR <= 1'b0;
      end
   end

   // Short-circuit catches on the raw comparator, so the kill does not wait.
   always_ff @(posedge clk_sys or posedge shortCircuit or negedge rst_n) begin
      if (!rst_n) scLatchR <= 1'b0;
      else if (shortCircuit) scLatchR <= 1'b1;
      else if (toggleClr) scLatchR <= 1'b0;
   end

   // =====================================================================
   // Outputs.
   // =====================================================================
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         gateR       <= 1'b0;
         dischargeOn <= 1'b0;
         ctlPullDown <= 1'b1;
         ctlChargeOn <= 1'b0;
         pgoodOut    <= 1'b0;
         pgoodOe     <= 1'b0;
      end else begin
         gateR       <= (stateNxt == ST_RUN);
         dischargeOn <= (stateNxt == ST_PD);
         ctlPullDown <= !supplyOk;
         ctlChargeOn <= supplyOk;
         pgoodOut    <= 1'b0;
         // The flag stays driven low until the insertion delay has ended.
         pgoodOe     <= !((stateR == ST_LOCK) || (stateR == ST_INSERT) || anyFault);
      end
   end

   // Gate is forced off asynchronously by the raw short flag.
   always_ff @(posedge clk_sys or posedge shortCircuit or negedge rst_n) begin
      if (!rst_n) gateEnable <= 1'b0;
      else if (shortCircuit) gateEnable <= 1'b0;
      else gateEnable <= gateR & ~scLatchR;
   end

   // =====================================================================
   // Assertions.
   // =====================================================================
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   AST_SC_OFF: assert property (shortCircuit |=> !gateEnable)
      else $error("Gate on after short circuit.");
   AST_INSERT_WAIT: assert property ($rose(stateR == ST_INSERT) |-> !gateR [*8])
      else $error("Gate charged during insertion delay.");
   AST_GATE_ON: assert property ($rose(gateR) |-> $past(ctlOn))
      else $error("Gate charged without on level.");
   AST_PD_DELAY: assert property ($rose(stateR == ST_PDWAIT) |-> !dischargeOn [*8])
      else $error("Discharge connected early.");
   AST_PD_AFTER: assert property ($rose(dischargeOn) |-> $past(pdEnter))
      else $error("Discharge connected before the full delay.");
   AST_LOCK_PULL: assert property (!supplyOk |=> ctlPullDown && !ctlChargeOn)
      else $error("Lockout pull-down missing.");
   AST_FAULT_FLAG: assert property (anyFault |=> !pgoodOe)
      else $error("Flag released during fault.");
   AST_OC_OFF: assert property (ocTrip |=> !gateR)
      else $error("Transistor on after over-current.");
   AST_HOT_OFF: assert property (hotR |=> !gateR)
      else $error("Transistor on while hot.");
   AST_LATCH_HOLD: assert property (latchR && !toggleClr |=> latchR)
      else $error("Latch dropped without clear.");

   COV_RUN: cover property ($rose(gateR));
   COV_PD: cover property ($rose(dischargeOn));
   COV_OC: cover property ($rose(ocTrip));
   COV_SC: cover property ($rose(scLatchR));
endmodule // efs_supervisor

// ### efs_pkg.sv
// Package for the eFuse switch supervisor: timing constants, enums, structs.
// Assumes a 40 MHz free-running system clock.
package efs_pkg;
   // =====================================================================
   // Clock and timing
   // =====================================================================
   localparam int unsigned CLK_HZ        = 40000000;
   localparam int unsigned PD_QUAL_US    = 80;
   localparam int unsigned PD_DELAY_MS   = 2;
   localparam int unsigned INSERT_MS     = 1;
   localparam int unsigned OC_BLANK_US   = 250;
   localparam int unsigned SS_TIMEOUT_MS = 200;
   localparam int unsigned PD_QUAL_CYC   = PD_QUAL_US * (CLK_HZ / 1000000) + 1;
   localparam int unsigned PD_DELAY_CYC  = PD_DELAY_MS * (CLK_HZ / 1000);
   localparam int unsigned INSERT_CYC    = INSERT_MS * (CLK_HZ / 1000);
   localparam int unsigned OC_BLANK_CYC  = OC_BLANK_US * (CLK_HZ / 1000000) + 1;
   localparam int unsigned SS_TIMEOUT_CYC = SS_TIMEOUT_MS * (CLK_HZ / 1000);
   localparam int unsigned TMR_W         = 24;

   // =====================================================================
   // Types
   // =====================================================================
   typedef enum logic [1:0] {CTL_OFF, CTL_MID, CTL_ON} efs_ctl_e;
   typedef enum logic [2:0] {ST_LOCK, ST_INSERT, ST_IDLE, ST_RUN, ST_PDWAIT, ST_PD} efs_state_e;

   // Comparator flags from the analog front end.
   typedef struct packed {
      logic ctlAbove14;   // Control input above 1.4 V.
      logic ctlBelow12;   // Control input below 1.2 V.
      logic ctlAbove08;   // Control input above 0.8 V.
      logic vddOk;        // Internal supply past lockout.
      logic vinOk;        // Input supply past lockout.
      logic overLimit;    // Sensed current above limit reference.
      logic outHigh70;    // Output above 70 % of input.
      logic gsHigh2;      // Gate-source above 2 V.
      logic gateFault;    // Charge pump to gate fault in normal operation.
      logic hotRise;      // Junction above 142 C.
      logic hotClear;     // Junction below 122 C (hysteresis point).
      logic vOutGood;     // Output above 90 % of input (soft start done).
   } efs_cmp_s;
endpackage

// ### efs_sync.sv
// Three-stage synchroniser with agreement filter for pin comparator flags.
// Assumes inputs are asynchronous to clk_sys.
`timescale 1ns/1ps
module efs_sync #(
   parameter int W = 12
) (
   // Clock and reset
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   // Data
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] s1R, s2R, s3R;

   // =====================================================================
   // Sync chain; the output only moves when stages two and three agree.
   // =====================================================================
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s1R  <= '0;
         s2R  <= '0;
         s3R  <= '0;
         dout <= '0;
      end else begin
         s1R  <= din;
         s2R  <= s1R;
         s3R  <= s2R;
         dout <= (s2R & s3R) | (dout & (s2R | s3R));
      end
   end
endmodule // efs_sync

// ### efs_host_model.sv
// Host-side partner: turns the control pin level into comparator flags
// and resolves the open-drain power-good pin.
// Assumes a pull-up on the power-good pin and clean host-driven levels.
`timescale 1ns/1ps
module efs_host_model (
   // Control pin level requested by the host, in millivolts
   input  var int    ctlMv,
   // Power-good pin from the supervisor
   input  wire logic pgoodOut,
   input  wire logic pgoodOe,
   // Comparator flags and resolved pin
   output logic      ctlAbove14,
   output logic      ctlBelow12,
   output logic      ctlAbove08,
   output logic      pgoodPin
);
   // =====================================================================
   // Control pin thresholds
   // =====================================================================
   // The host only drives on, off or mid levels, never a slow sweep.
   assign ctlAbove14 = (ctlMv > 1400);
   assign ctlBelow12 = (ctlMv < 1200);
   assign ctlAbove08 = (ctlMv > 800);
   // A released pin rises to the pull-up, never to the last driven value.
   // The enable is low while the supervisor drives the pin.
   assign pgoodPin = pgoodOe ? 1'b1 : pgoodOut;
endmodule // efs_host_model

// ### efuse_switch_supervisor_tb.sv
// Self-checking bench for the supervisor, with a behavioural model.
// Assumes the package constants as delivered; soft-start is not run.
`timescale 1ns/1ps
module efuse_switch_supervisor_tb;
   import efs_pkg::*;
   // =====================================================================
   // Signals and model state
   // =====================================================================
   logic     clk_sys, rst_n, shortCircuit, gateEnable, dischargeOn;
   logic     ctlPullDown, ctlChargeOn, pgoodOut, pgoodOe, pgoodPin;
   logic     a14, b12, a08;
   efs_cmp_s cmp, cmpIn;
   int       ctlMv, n_fail, n_tests, seed, len;
   int       mIns, mOn, mLatch, mHot;

   // Clock at 40 MHz.
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   // Control flags come from the host model, the rest from the bench.
   always_comb begin
      cmpIn = cmp;
      cmpIn.ctlAbove14 = a14;
      cmpIn.ctlBelow12 = b12;
      cmpIn.ctlAbove08 = a08;
   end

   efs_supervisor DUT (.clk_sys(clk_sys), .rst_n(rst_n), .cmpIn(cmpIn), .shortCircuit(shortCircuit),
      .gateEnable(gateEnable), .dischargeOn(dischargeOn), .ctlPullDown(ctlPullDown),
      .ctlChargeOn(ctlChargeOn), .pgoodOut(pgoodOut), .pgoodOe(pgoodOe));
   efs_host_model HOST (.ctlMv(ctlMv), .pgoodOut(pgoodOut), .pgoodOe(pgoodOe),
      .ctlAbove14(a14), .ctlBelow12(b12), .ctlAbove08(a08), .pgoodPin(pgoodPin));

   // =====================================================================
   // Tasks
   // =====================================================================
   // Inputs always move 2 ns after the edge, clear of sampling.
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #2;
   endtask

   task automatic chk(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Gate and flag as the model predicts them.
   task automatic model_chk();
      chk(gateEnable, logic'(mIns != 0 && mOn != 0 && mLatch == 0 && mHot == 0));
      chk(pgoodOe, logic'(!(mIns == 0 || mLatch != 0 || mHot != 0)));
      chk(pgoodPin, logic'(!(mIns == 0 || mLatch != 0 || mHot != 0)));
   endtask

   // Bounded wait on gate (sel 0) or flag enable (sel 1, low means driven).
   task automatic wait_for(input int sel, input logic val, input int lim);
      int k;
      k = 0;
      while (((sel == 0) ? gateEnable : pgoodOe) !== val && k < lim) begin
         cyc(1);
         k++;
      end
      if (k >= lim) begin
         n_fail++;
         $display("ERROR t=%0t wait sel=%h got=%h exp=%h", $time, sel, (sel == 0) ? gateEnable : pgoodOe, val);
         wrap_up();
      end
   endtask

   task automatic wrap_up();
      $display("comparisons=%0d mismatches=%0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // =====================================================================
   // Main sequence
   // =====================================================================
   initial begin
      seed = 32'h5a5e;
      cmp = '0;
      cmp.hotClear = 1'b1;
      ctlMv = 0;
      shortCircuit = 1'b0;
      rst_n = 1'b0;
      {n_fail, n_tests, mIns, mOn, mLatch, mHot} = '0;
      cyc(8);
      rst_n = 1'b1;
      cyc(6);
      chk(ctlPullDown, 1'b1);
      chk(ctlChargeOn, 1'b0);
      model_chk();
      $display("test lockout done");
      // On is requested early; the gate must still wait out insertion.
      cmp.vddOk = 1'b1;
      cmp.vinOk = 1'b1;
      ctlMv = 1500;
      mOn = 1;
      cyc(10);
      chk(ctlPullDown, 1'b0);
      chk(ctlChargeOn, 1'b1);
      cyc(38900);
      model_chk();
      mIns = 1;
      wait_for(1, 1'b1, 1200);
      wait_for(0, 1'b1, 10);
      model_chk();
      $display("test insertion done");
      // A random burst shorter than the blanking time must not trip.
      cmp.vOutGood = 1'b1;
      cyc(5);
      len = 100 + ($unsigned($random(seed)) % 5000);
      cmp.overLimit = 1'b1;
      cyc(len);
      cmp.overLimit = 1'b0;
      cyc(10);
      model_chk();
      cmp.overLimit = 1'b1;
      cyc(9900);
      model_chk();
      mLatch = 1;
      wait_for(0, 1'b0, 200);
      wait_for(1, 1'b0, 10);
      cmp.overLimit = 1'b0;
      cyc(20);
      model_chk();
      $display("test over-limit done");
      // Toggling the control pin clears the latch; restart may re-time.
      ctlMv = 0;
      cyc(10);
      ctlMv = 1500;
      mLatch = 0;
      wait_for(0, 1'b1, 41000);
      wait_for(1, 1'b1, 100);
      model_chk();
      // The short-circuit path must act before any clock edge.
      shortCircuit = 1'b1;
      #1;
      chk(gateEnable, 1'b0);
      mLatch = 1;
      cyc(3);
      shortCircuit = 1'b0;
      cyc(20);
      model_chk();
      $display("test short-circuit done");
      // Heat holds the flag through the hysteresis band even after a toggle.
      cmp.hotRise = 1'b1;
      cmp.hotClear = 1'b0;
      {mHot, mOn, mLatch} = {32'd1, 32'd0, 32'd0};
      ctlMv = 0;
      cyc(20);
      model_chk();
      cmp.hotRise = 1'b0;
      cyc(20);
      model_chk();
      cmp.hotClear = 1'b1;
      mHot = 0;
      wait_for(1, 1'b1, 50);
      $display("test over-temperature done");
      // Start-up shorts hold the flag only while they are present.
      cmp.outHigh70 = 1'b1;
      cyc(10);
      chk(pgoodOe, 1'b0);
      cmp.outHigh70 = 1'b0;
      cmp.gsHigh2 = 1'b1;
      cyc(10);
      chk(pgoodOe, 1'b0);
      cmp.gsHigh2 = 1'b0;
      cyc(10);
      chk(pgoodOe, 1'b1);
      chk(pgoodPin, 1'b1);
      $display("test start-up shorts done");
      // Mid level qualifies, but discharge needs the long delay first.
      ctlMv = 1100;
      cyc(3300);
      chk(dischargeOn, 1'b0);
      chk(gateEnable, 1'b0);
      ctlMv = 0;
      cyc(20);
      chk(dischargeOn, 1'b0);
      $display("test pull-down done");
      wrap_up();
   end
endmodule // efuse_switch_supervisor_tb
